// ### src/pocf_pkg.sv
// Constants for the proximity filter, offset and calibration block
package pocf_pkg;
	localparam logic [7:0] ADDR_FILTER_CFG = 8'hb3;
	localparam logic [7:0] ADDR_OFFSET_MAG = 8'hc0;
	localparam logic [7:0] ADDR_OFFSET_SIGN = 8'hc1;
	localparam logic [7:0] ADDR_CAL_CONTROL = 8'hd7;
	localparam int FILT_DEPTH_LSB = 0;
	localparam int SIGN_BIT = 0;
	localparam int CAL_START_BIT = 0;
	localparam int CAL_SPACING_BIT = 4;
	localparam int CAL_ELEC_BIT = 5;
	localparam int CAL_AVG_BIT = 7;
	localparam logic [1:0] FILTER_RST = 2'h0;
	localparam logic [7:0] OFFSET_MAG_RST = 8'h00;
	localparam logic OFFSET_SIGN_RST = 1'b0;
	localparam int SAR_BITS = 9;
	localparam logic [8:0] SAR_MID = 9'h100;
	localparam logic [7:0] MAG_MAX = 8'hff;
	localparam int HIST_DEPTH = 8;
	typedef enum logic [1:0] {CAL_IDLE, CAL_TRIAL, CAL_WAIT} pocf_cal_e;
endpackage : pocf_pkg

// ### src/pocf_top.sv
// Proximity moving-average filter, crosstalk offset and offset calibration sequencer
`timescale 1ns/1ps
`default_nettype none

module pocf_top import pocf_pkg::*; #(
	parameter int DW = 10
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [2:0] hw_sample_avg_count,
	input wire logic [2:0] search_goal_sel,
	input wire logic adc_sample_valid,
	input wire logic [DW-1:0] adc_sample,
	input wire logic cal_done_clr,
	output logic [DW-1:0] prox_result,
	output logic prox_result_valid,
	output logic [7:0] afe_offset_magnitude,
	output logic afe_offset_sign,
	output logic pd_connect,
	output logic sample_spacing_en,
	output logic cal_busy,
	output logic cal_done_flag
);
	localparam int AW = DW + 7;

	function automatic logic [DW-1:0] goal_value(input logic [2:0] sel);
		logic [DW:0] one;
		one = {{DW{1'b0}}, 1'b1};
		goal_value = DW'((one << (32'(sel) + 2)) - one);
	endfunction : goal_value

	function automatic logic [8:0] sar_to_sm(input logic [8:0] code);
		logic [9:0] v;
		logic [9:0] neg;
		v = {1'b0, code} - {1'b0, SAR_MID};
		neg = 10'h000 - v;
		if (v[9]) begin
			sar_to_sm = {1'b1, (neg[8] ? MAG_MAX : neg[7:0])};
		end else begin
			sar_to_sm = {1'b0, v[7:0]};
		end
	endfunction : sar_to_sm

	// Register file
	logic [1:0] depth_sel_q, depth_sel_d;
	logic [7:0] offset_magnitude_q, offset_magnitude_d;
	logic offset_sign_q, offset_sign_d;
	logic cal_hw_avg_en_q, cal_hw_avg_en_d;
	logic cal_elec_q, cal_elec_d;
	logic cal_sample_spacing_en_q, cal_sample_spacing_en_d;
	logic cal_go_q, cal_go_d;
	logic [7:0] rdata_q, rdata_d;
	logic done_q, done_d;

	// Calibration sequencer
	pocf_cal_e state_q, state_d;
	logic [8:0] code_q, code_d;
	logic [3:0] bit_q, bit_d;
	logic finish;
	logic busy_q, busy_d;

	// Hardware averaging and filter
	logic [AW-1:0] acc_q, acc_d;
	logic [7:0] cnt_q, cnt_d;
	logic [DW-1:0] hw_q, hw_d;
	logic hw_vld_q, hw_vld_d;
	logic [DW-1:0] hist_q [HIST_DEPTH], hist_d [HIST_DEPTH];
	logic [DW-1:0] res_q, res_d;
	logic res_vld_q, res_vld_d;
	logic [7:0] mag_out_q, mag_out_d;
	logic sign_out_q, sign_out_d;
	logic pd_q, pd_d;
	logic spc_q, spc_d;

	logic cal_active;
	assign cal_active = (state_q != CAL_IDLE);

	always_comb begin
		state_d = state_q;
		code_d = code_q;
		bit_d = bit_q;
		finish = 1'b0;
		case (state_q)
			CAL_IDLE: begin
				if (cal_go_q) begin
					state_d = CAL_TRIAL;
					code_d = 9'h000;
					bit_d = 4'(SAR_BITS - 1);
				end
			end
			CAL_TRIAL: begin
				code_d = code_q | (9'h001 << bit_q);
				state_d = CAL_WAIT;
			end
			CAL_WAIT: begin
				if (hw_vld_q) begin
					// A larger code means more positive offset, which lowers the result
					if (hw_q <= goal_value(search_goal_sel)) begin
						code_d = code_q & ~(9'h001 << bit_q);
					end
					if (bit_q == 4'h0) begin
						state_d = CAL_IDLE;
						finish = 1'b1;
					end else begin
						bit_d = bit_q - 4'h1;
						state_d = CAL_TRIAL;
					end
				end
			end
			default: begin
				state_d = CAL_IDLE;
			end
		endcase
		busy_d = (state_d != CAL_IDLE);
	end

	always_comb begin
		logic [8:0] found;
		found = sar_to_sm(code_d);
		depth_sel_d = depth_sel_q;
		offset_magnitude_d = offset_magnitude_q;
		offset_sign_d = offset_sign_q;
		cal_hw_avg_en_d = cal_hw_avg_en_q;
		cal_elec_d = cal_elec_q;
		cal_sample_spacing_en_d = cal_sample_spacing_en_q;
		cal_go_d = cal_go_q;
		rdata_d = rdata_q;
		done_d = done_q;
		if (reg_wr) begin
			case (reg_addr)
				ADDR_FILTER_CFG: depth_sel_d = reg_wdata[FILT_DEPTH_LSB +: 2];
				ADDR_OFFSET_MAG: offset_magnitude_d = reg_wdata;
				ADDR_OFFSET_SIGN: offset_sign_d = reg_wdata[SIGN_BIT];
				ADDR_CAL_CONTROL: begin
					cal_hw_avg_en_d = reg_wdata[CAL_AVG_BIT];
					cal_elec_d = reg_wdata[CAL_ELEC_BIT];
					cal_sample_spacing_en_d = reg_wdata[CAL_SPACING_BIT];
					// A running sequence keeps its start bit until it finishes
					cal_go_d = reg_wdata[CAL_START_BIT] | cal_active;
				end
				default: begin
				end
			endcase
		end
		if (cal_done_clr) begin
			done_d = 1'b0;
		end
		if (finish) begin
			offset_magnitude_d = found[7:0];
			offset_sign_d = found[8];
			cal_go_d = 1'b0;
			done_d = 1'b1;
		end
		if (reg_rd) begin
			case (reg_addr)
				ADDR_FILTER_CFG: rdata_d = {6'h00, depth_sel_q};
				ADDR_OFFSET_MAG: rdata_d = offset_magnitude_q;
				ADDR_OFFSET_SIGN: rdata_d = {7'h00, offset_sign_q};
				ADDR_CAL_CONTROL: rdata_d = {cal_hw_avg_en_q, 1'b0, cal_elec_q, cal_sample_spacing_en_q,
					3'h0, cal_go_q};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_comb begin
		logic [2:0] lg;
		logic [AW-1:0] sum;
		logic [AW-1:0] hsum;
		logic [7:0] last;
		logic [2:0] flog;
		logic [8:0] trial;
		lg = cal_active ? (cal_hw_avg_en_q ? hw_sample_avg_count : 3'h0) : hw_sample_avg_count;
		last = 8'((9'h001 << lg) - 9'h001);
		sum = acc_q + AW'(adc_sample);
		flog = {1'b0, depth_sel_q};
		hsum = AW'(hw_q);
		trial = sar_to_sm(code_d);
		acc_d = acc_q;
		cnt_d = cnt_q;
		hw_d = hw_q;
		hw_vld_d = 1'b0;
		if (adc_sample_valid) begin
			if (cnt_q >= last) begin
				hw_d = DW'(sum >> lg);
				hw_vld_d = 1'b1;
				acc_d = '0;
				cnt_d = 8'h00;
			end else begin
				acc_d = sum;
				cnt_d = cnt_q + 8'h01;
			end
		end
		// Samples taken under the previous trial offset are dropped
		if (state_q == CAL_TRIAL) begin
			acc_d = '0;
			cnt_d = 8'h00;
			hw_vld_d = 1'b0;
		end
		for (int i = 0; i < HIST_DEPTH; i++) begin
			hist_d[i] = hist_q[i];
		end
		res_d = res_q;
		res_vld_d = 1'b0;
		if (hw_vld_q && !cal_active) begin
			for (int i = HIST_DEPTH - 1; i > 0; i--) begin
				hist_d[i] = hist_q[i - 1];
			end
			hist_d[0] = hw_q;
			for (int i = 1; i < HIST_DEPTH; i++) begin
				if (i < (1 << flog)) begin
					hsum = hsum + AW'(hist_q[i - 1]);
				end
			end
			res_d = (depth_sel_q == 2'h0) ? hw_q : DW'(hsum >> flog);
			res_vld_d = 1'b1;
		end
		// Trial offset reaches the front end as the sequencer enters its wait
		mag_out_d = busy_d ? trial[7:0] : offset_magnitude_d;
		sign_out_d = busy_d ? trial[8] : offset_sign_d;
		pd_d = !(cal_active && cal_elec_q);
		spc_d = cal_active ? cal_sample_spacing_en_q : 1'b1;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			depth_sel_q <= FILTER_RST;
			offset_magnitude_q <= OFFSET_MAG_RST;
			offset_sign_q <= OFFSET_SIGN_RST;
			cal_hw_avg_en_q <= 1'b0;
			cal_elec_q <= 1'b0;
			cal_sample_spacing_en_q <= 1'b0;
			cal_go_q <= 1'b0;
			rdata_q <= 8'h00;
			done_q <= 1'b0;
			state_q <= CAL_IDLE;
			code_q <= 9'h000;
			bit_q <= 4'h0;
			acc_q <= '0;
			cnt_q <= 8'h00;
			hw_q <= '0;
			hw_vld_q <= 1'b0;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_q[i] <= '0;
			end
			res_q <= '0;
			res_vld_q <= 1'b0;
			mag_out_q <= OFFSET_MAG_RST;
			sign_out_q <= OFFSET_SIGN_RST;
			pd_q <= 1'b1;
			spc_q <= 1'b1;
		end else begin
			depth_sel_q <= depth_sel_d;
			offset_magnitude_q <= offset_magnitude_d;
			offset_sign_q <= offset_sign_d;
			cal_hw_avg_en_q <= cal_hw_avg_en_d;
			cal_elec_q <= cal_elec_d;
			cal_sample_spacing_en_q <= cal_sample_spacing_en_d;
			cal_go_q <= cal_go_d;
			rdata_q <= rdata_d;
			done_q <= done_d;
			state_q <= state_d;
			code_q <= code_d;
			bit_q <= bit_d;
			acc_q <= acc_d;
			cnt_q <= cnt_d;
			hw_q <= hw_d;
			hw_vld_q <= hw_vld_d;
			for (int i = 0; i < HIST_DEPTH; i++) begin
				hist_q[i] <= hist_d[i];
			end
			res_q <= res_d;
			res_vld_q <= res_vld_d;
			mag_out_q <= mag_out_d;
			sign_out_q <= sign_out_d;
			pd_q <= pd_d;
			spc_q <= spc_d;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= busy_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign prox_result = res_q;
	assign prox_result_valid = res_vld_q;
	assign afe_offset_magnitude = mag_out_q;
	assign afe_offset_sign = sign_out_q;
	assign pd_connect = pd_q;
	assign sample_spacing_en = spc_q;
	assign cal_busy = busy_q;
	assign cal_done_flag = done_q;
endmodule : pocf_top

`default_nettype wire

// ### testbench/pocf_top_monitor.sv
// Timing checker for the proximity filter and offset calibration block
`timescale 1ns/1ps
`default_nettype none
module pocf_top_monitor import pocf_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic [2:0] hw_sample_avg_count,
	input wire logic adc_sample_valid,
	input wire logic cal_done_clr,
	input wire logic prox_result_valid,
	input wire logic pd_connect,
	input wire logic sample_spacing_en,
	input wire logic cal_busy,
	input wire logic cal_done_flag
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	sequence go_s;
		reg_wr && reg_addr == ADDR_CAL_CONTROL && reg_wdata[CAL_START_BIT] && !cal_busy;
	endsequence
	cal_launch_a: assert property (go_s |-> ##2 cal_busy)
		else $error("calibration not started");
	elec_pd_off_a: assert property (go_s ##0 reg_wdata[CAL_ELEC_BIT] |-> ##3 !pd_connect)
		else $error("photodiode still connected");
	spacing_cal_a: assert property (go_s ##0 !reg_wdata[CAL_SPACING_BIT] |-> ##3 !sample_spacing_en)
		else $error("spacing not ignored");
	spacing_idle_a: assert property (!cal_busy && !$past(cal_busy) |-> sample_spacing_en)
		else $error("spacing off when idle");
	done_on_end_a: assert property ($fell(cal_busy) |-> cal_done_flag)
		else $error("done flag missing");
	done_clear_a: assert property (cal_done_clr |=> cal_done_flag == $fell(cal_busy))
		else $error("done flag clear wrong");
	quiet_in_cal_a: assert property (cal_busy && $past(cal_busy, 2) |-> !prox_result_valid)
		else $error("result updated in calibration");
	bypass_lat_a: assert property ((adc_sample_valid && hw_sample_avg_count == 3'h0 && !cal_busy)
		##1 !cal_busy |-> ##1 prox_result_valid)
		else $error("result not produced");
	optical_pd_on_a: assert property (go_s ##0 !reg_wdata[CAL_ELEC_BIT] |-> ##3 pd_connect)
		else $error("photodiode cut in optical calibration");
endmodule : pocf_top_monitor
`default_nettype wire

// ### testbench/test_pocf_top.sv
// Self-checking bench for the proximity filter and offset calibration block
`timescale 1ns/1ps
`default_nettype none
module test_pocf_top import pocf_pkg::*;;
	logic clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, adc_sample_valid = 0, cal_done_clr = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, afe_offset_magnitude;
	logic [2:0] hw_sample_avg_count = 0, search_goal_sel = 3'h2;
	logic [9:0] adc_sample = 0, prox_result;
	logic prox_result_valid, afe_offset_sign, pd_connect, sample_spacing_en, cal_busy, cal_done_flag;
	logic [7:0] ra[5] = '{ADDR_FILTER_CFG, ADDR_OFFSET_MAG, ADDR_OFFSET_SIGN, ADDR_CAL_CONTROL, 8'hb4};
	int fails = 0, comparisons = 0, h[8], n;
	pocf_top dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hw_sample_avg_count,
		.search_goal_sel, .adc_sample_valid, .adc_sample, .cal_done_clr, .prox_result, .prox_result_valid,
		.afe_offset_magnitude, .afe_offset_sign, .pd_connect, .sample_spacing_en, .cal_busy, .cal_done_flag);
	initial forever #50 clk = ~clk;
	task report_and_stop;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : report_and_stop
	task chk(string s, logic [9:0] e, logic [9:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task wr_reg(logic [7:0] ad, logic [7:0] d);
		@(negedge clk);
		reg_addr = ad;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge clk);
		reg_wr = 0;
	endtask : wr_reg
	task rd_reg(logic [7:0] ad, logic [7:0] e);
		@(negedge clk);
		reg_addr = ad;
		reg_rd = 1;
		@(negedge clk);
		reg_rd = 0;
		@(negedge clk);
		chk("register", {2'h0, e}, {2'h0, reg_rdata});
	endtask : rd_reg
	task smp(int v);
		@(negedge clk);
		adc_sample_valid = 1;
		adc_sample = v[9:0];
		@(negedge clk);
		adc_sample_valid = 0;
	endtask : smp
	task feed(int v, int hv, int d);
		int s;
		s = 0;
		for (int i = 7; i > 0; i--) h[i] = h[i - 1];
		h[0] = hv;
		for (int i = 0; i < (1 << d); i++) s += h[i];
		smp(v);
		for (n = 0; n < 4 && prox_result_valid !== 1'b1; n++) @(negedge clk);
		chk("valid", 10'h1, {9'h0, prox_result_valid});
		chk("result", 10'(s >> d), prox_result);
	endtask : feed
	task cal(int base, logic [7:0] ctl);
		int c, t, v, ns;
		c = 0;
		ns = 0;
		for (int b = 8; b >= 0; b--) begin
			t = c | (1 << b);
			if (base - t + 256 > (4 << search_goal_sel) - 1) c = t;
		end
		v = c == 0 ? -255 : c - 256;
		wr_reg(ADDR_CAL_CONTROL, ctl);
		repeat (3) @(negedge clk);
		for (int k = 0; k < 200 && cal_busy === 1'b1; k++) begin
			repeat (6) @(negedge clk);
			t = afe_offset_sign ? base + afe_offset_magnitude : base - afe_offset_magnitude;
			if (cal_busy === 1'b1) begin
				smp(t < 0 ? 0 : t);
				ns++;
			end
		end
		chk("samples", 10'(9 << (ctl[CAL_AVG_BIT] ? hw_sample_avg_count : 0)), 10'(ns));
		chk("done", 10'h1, {9'h0, cal_done_flag});
		rd_reg(ADDR_OFFSET_MAG, 8'(v < 0 ? -v : v));
		rd_reg(ADDR_OFFSET_SIGN, {7'h0, v < 0});
		rd_reg(ADDR_CAL_CONTROL, ctl & 8'hfe);
		cal_done_clr = 1;
		@(negedge clk);
		cal_done_clr = 0;
		chk("clear", 10'h0, {9'h0, cal_done_flag});
	endtask : cal
	initial begin
		repeat (2) @(negedge clk);
		rst = 0;
		foreach (ra[i]) rd_reg(ra[i], 8'h00);
		wr_reg(ADDR_OFFSET_MAG, 8'h5a);
		wr_reg(ADDR_OFFSET_SIGN, 8'h01);
		rd_reg(ADDR_OFFSET_SIGN, 8'h01);
		chk("afe", 10'h15a, {1'b0, afe_offset_sign, afe_offset_magnitude});
		for (int d = 0; d < 4; d++) begin
			wr_reg(ADDR_FILTER_CFG, 8'(d));
			rd_reg(ADDR_FILTER_CFG, 8'(d));
			for (int j = 0; j < 6; j++) feed(37 * j + 11 * d, 37 * j + 11 * d, d);
		end
		hw_sample_avg_count = 3'h2;
		smp(400);
		smp(401);
		smp(402);
		feed(405, 402, 3);
		hw_sample_avg_count = 3'h1;
		cal(100, 8'h91);
		cal(5, 8'h01);
		search_goal_sel = 3'h7;
		cal(600, 8'h21);
		wr_reg(ADDR_CAL_CONTROL, 8'h01);
		repeat (4) @(negedge clk);
		rst = 1;
		@(negedge clk);
		rst = 0;
		chk("reset", 10'h100, {cal_busy, pd_connect, afe_offset_magnitude});
		rd_reg(ADDR_OFFSET_MAG, 8'h00);
		report_and_stop();
	end
	initial begin
		#1000000;
		fails++;
		report_and_stop();
	end
endmodule : test_pocf_top
bind pocf_top pocf_top_monitor mon (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .hw_sample_avg_count,
	.adc_sample_valid, .cal_done_clr, .prox_result_valid, .pd_connect, .sample_spacing_en, .cal_busy, .cal_done_flag);
`default_nettype wire
